// ### shared/idc_pkg.sv
// shared constants and carrier types for the inactivity detect configuration block
package idc_pkg;

	// register byte addresses
	localparam logic [7:0] IDC_ADDR_X_HIGH   = 8'h2a;
	localparam logic [7:0] IDC_ADDR_X_LOW    = 8'h2b;
	localparam logic [7:0] IDC_ADDR_Y_HIGH   = 8'h2c;
	localparam logic [7:0] IDC_ADDR_Y_LOW    = 8'h2d;
	localparam logic [7:0] IDC_ADDR_Z_HIGH   = 8'h2e;
	localparam logic [7:0] IDC_ADDR_Z_LOW    = 8'h2f;
	localparam logic [7:0] IDC_ADDR_TIME_HI  = 8'h30;
	localparam logic [7:0] IDC_ADDR_TIME_LO  = 8'h31;
	localparam logic [7:0] IDC_ADDR_MW_HIGH  = 8'h32;
	localparam logic [7:0] IDC_ADDR_MW_LOW   = 8'h33;

	// low register field positions
	localparam int IDC_LOW_THR_MSB = 7;
	localparam int IDC_LOW_THR_LSB = 5;
	localparam int IDC_LOW_REF_BIT = 1;
	localparam int IDC_LOW_EN_BIT  = 0;

	// reset value of every register
	localparam logic [7:0] IDC_REG_RESET = 8'h00;

	// widths
	localparam int IDC_SAMPLE_W = 12;
	localparam int IDC_LIMIT_W  = 11;
	localparam int IDC_DUR_W    = 16;

	// duration code weight, in microseconds, and the clock rate
	localparam int IDC_CODE_SLOW_US = 26000;
	localparam int IDC_CODE_FAST_US = 13000;
	localparam int IDC_CLK_HZ       = 50000000;
	localparam int IDC_CODE_SLOW_CYC = (IDC_CODE_SLOW_US / 1000) * (IDC_CLK_HZ / 1000);
	localparam int IDC_CODE_FAST_CYC = (IDC_CODE_FAST_US / 1000) * (IDC_CLK_HZ / 1000);
	localparam int IDC_TICK_W        = 21;

	// one acceleration sample on all three axes
	typedef struct packed {
		logic signed [IDC_SAMPLE_W-1:0] x;
		logic signed [IDC_SAMPLE_W-1:0] y;
		logic signed [IDC_SAMPLE_W-1:0] z;
	} idc_sample_t;

	// register port request from the serial interface
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} idc_reg_req_t;

endpackage : idc_pkg

// ### rtl/idc_top.sv
// inactivity detection configuration registers and decision logic
// Contract
// [R1] each axis holds an unsigned eleven-bit still limit, 100 mg per code
// [R2] magnitude of twelve-bit signed sample compared with axis still limit
// [R3] high register holds limit bits 10:3, low register bits 7:5 hold 2:0
// [R4] x low register bit 1 selects referenced (1) or absolute (0) processing
// [R5] low register bit 0 includes axis (1) or excludes it (0)
// [R6] event only after all enabled axes stay below limit for programmed duration
// [R7] duration is low register as bits 7:0 and high register as 15:8
// [R8] one duration code is 26 ms up to 3200 Hz, 13 ms at 6400 Hz
// [R9] all registers of this block reset to zero
// [R10] motion warning compares sample magnitude with unsigned eleven-bit limit
// [R11] motion warning x high register holds bits 10:3; exceeding drives warning (code warns at or above the limit)
// [R12] motion warning x low: bits 7:5 limit, bit 1 referenced select, bit 0 enable
// [R13] timer counts still time, restarts on any enabled axis at or above limit
// [R14] reserved low register bits read zero and ignore writes
module idc_top
	import idc_pkg::*;
#(
	parameter int CODE_SLOW_CYC = IDC_CODE_SLOW_CYC,
	parameter int CODE_FAST_CYC = IDC_CODE_FAST_CYC
)(
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire idc_reg_req_t  reg_req,
	output logic [7:0]         reg_rdata,
	input  wire logic          sample_valid,
	input  wire idc_sample_t   sample,
	input  wire logic          rate_6400,
	output logic               still_event,
	output logic               still_active,
	output logic               motion_warn
);

	// the tick counter holds codes of up to 2^21 - 1 cycles; longer codes are refused at elaboration
	if (CODE_SLOW_CYC < 1 || CODE_FAST_CYC < 1 || CODE_SLOW_CYC >= (1 << IDC_TICK_W)
		|| CODE_FAST_CYC >= (1 << IDC_TICK_W))
	begin : g_code_check
		$error("idc_top: code cycle counts out of range");
	end

	// magnitude of a signed value, one bit wider than needed so -2048 stays exact
	function automatic logic [IDC_SAMPLE_W:0] idc_mag(input logic signed [IDC_SAMPLE_W:0] v);
		idc_mag = v[IDC_SAMPLE_W] ? (IDC_SAMPLE_W+1)'(-v) : v;
	endfunction : idc_mag

	// reading of one axis against a limit: absolute, or distance from a reference
	function automatic logic idc_below(
		input logic signed [IDC_SAMPLE_W-1:0] s,
		input logic signed [IDC_SAMPLE_W-1:0] r,
		input logic                           use_ref,
		input logic [IDC_LIMIT_W-1:0]         lim
	);
		logic signed [IDC_SAMPLE_W:0] d;
		// one extra bit so a referenced distance across full scale cannot wrap
		d = use_ref ? (IDC_SAMPLE_W+1)'(s - r) : (IDC_SAMPLE_W+1)'(s);
		idc_below = idc_mag(d) < {2'b00, lim}; // [R2] [R10]
	endfunction : idc_below

	// register storage; low registers keep only their defined bits
	logic [7:0]             x_high_r, y_high_r, z_high_r, mw_high_r;
	logic [2:0]             x_lo_thr_r, y_lo_thr_r, z_lo_thr_r, mw_lo_thr_r;
	logic                   still_ref_r, still_use_x_r, still_use_y_r, still_use_z_r;
	logic                   mw_ref_r, mw_use_x_r;
	logic [7:0]             dur_high_r, dur_low_r;

	// write strobes
	wire wr_x_high  = reg_req.wr && reg_req.addr == IDC_ADDR_X_HIGH;
	wire wr_x_low   = reg_req.wr && reg_req.addr == IDC_ADDR_X_LOW;
	wire wr_y_high  = reg_req.wr && reg_req.addr == IDC_ADDR_Y_HIGH;
	wire wr_y_low   = reg_req.wr && reg_req.addr == IDC_ADDR_Y_LOW;
	wire wr_z_high  = reg_req.wr && reg_req.addr == IDC_ADDR_Z_HIGH;
	wire wr_z_low   = reg_req.wr && reg_req.addr == IDC_ADDR_Z_LOW;
	wire wr_dur_hi  = reg_req.wr && reg_req.addr == IDC_ADDR_TIME_HI;
	wire wr_dur_lo  = reg_req.wr && reg_req.addr == IDC_ADDR_TIME_LO;
	wire wr_mw_high = reg_req.wr && reg_req.addr == IDC_ADDR_MW_HIGH;
	wire wr_mw_low  = reg_req.wr && reg_req.addr == IDC_ADDR_MW_LOW;
	wire [2:0] wd_thr = reg_req.wdata[IDC_LOW_THR_MSB:IDC_LOW_THR_LSB];
	wire       wd_ref = reg_req.wdata[IDC_LOW_REF_BIT];
	wire       wd_en  = reg_req.wdata[IDC_LOW_EN_BIT];

	// register writes; everything clears on reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			x_high_r      <= IDC_REG_RESET; // [R9]
			y_high_r      <= IDC_REG_RESET;
			z_high_r      <= IDC_REG_RESET;
			mw_high_r     <= IDC_REG_RESET;
			dur_high_r    <= IDC_REG_RESET;
			dur_low_r     <= IDC_REG_RESET;
			x_lo_thr_r    <= 3'h0;
			y_lo_thr_r    <= 3'h0;
			z_lo_thr_r    <= 3'h0;
			mw_lo_thr_r   <= 3'h0;
			still_ref_r   <= 1'b0;
			still_use_x_r <= 1'b0;
			still_use_y_r <= 1'b0;
			still_use_z_r <= 1'b0;
			mw_ref_r      <= 1'b0;
			mw_use_x_r    <= 1'b0;
		end
		else
		begin
			if (wr_x_high)  x_high_r  <= reg_req.wdata; // [R3]
			if (wr_y_high)  y_high_r  <= reg_req.wdata;
			if (wr_z_high)  z_high_r  <= reg_req.wdata;
			if (wr_mw_high) mw_high_r <= reg_req.wdata; // [R11]
			if (wr_dur_hi)  dur_high_r <= reg_req.wdata; // [R7]
			if (wr_dur_lo)  dur_low_r  <= reg_req.wdata;
			if (wr_x_low)
			begin
				x_lo_thr_r    <= wd_thr;
				still_ref_r   <= wd_ref; // [R4]
				still_use_x_r <= wd_en;  // [R5]
			end
			if (wr_y_low)
			begin
				y_lo_thr_r    <= wd_thr;
				still_use_y_r <= wd_en;
			end
			if (wr_z_low)
			begin
				z_lo_thr_r    <= wd_thr;
				still_use_z_r <= wd_en;
			end
			if (wr_mw_low)
			begin
				mw_lo_thr_r <= wd_thr; // [R12]
				mw_ref_r    <= wd_ref;
				mw_use_x_r  <= wd_en;
			end
		end
	end

	// assembled limits and duration
	wire [IDC_LIMIT_W-1:0] still_limit_x       = {x_high_r, x_lo_thr_r}; // [R1] [R3]
	wire [IDC_LIMIT_W-1:0] still_limit_y       = {y_high_r, y_lo_thr_r};
	wire [IDC_LIMIT_W-1:0] still_limit_z       = {z_high_r, z_lo_thr_r};
	wire [IDC_LIMIT_W-1:0] motion_warn_limit_x = {mw_high_r, mw_lo_thr_r}; // [R10] [R12]
	wire [IDC_DUR_W-1:0]   still_duration      = {dur_high_r, dur_low_r}; // [R7]

	// read mux; unused low bits come back zero
	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (reg_req.addr)
			IDC_ADDR_X_HIGH:  rd_mux = x_high_r;
			IDC_ADDR_X_LOW:   rd_mux = {x_lo_thr_r, 3'b000, still_ref_r, still_use_x_r}; // [R14]
			IDC_ADDR_Y_HIGH:  rd_mux = y_high_r;
			IDC_ADDR_Y_LOW:   rd_mux = {y_lo_thr_r, 4'h0, still_use_y_r}; // [R14]
			IDC_ADDR_Z_HIGH:  rd_mux = z_high_r;
			IDC_ADDR_Z_LOW:   rd_mux = {z_lo_thr_r, 4'h0, still_use_z_r};
			IDC_ADDR_TIME_HI: rd_mux = dur_high_r;
			IDC_ADDR_TIME_LO: rd_mux = dur_low_r;
			IDC_ADDR_MW_HIGH: rd_mux = mw_high_r;
			IDC_ADDR_MW_LOW:  rd_mux = {mw_lo_thr_r, 3'b000, mw_ref_r, mw_use_x_r};
			default:          rd_mux = 8'h00;
		endcase
	end

	// per-sample decisions; references give the referenced-mode origin
	idc_sample_t ref_r;
	logic signed [IDC_SAMPLE_W-1:0] mw_prev_r;
	wire below_x   = idc_below(sample.x, ref_r.x, still_ref_r, still_limit_x);
	wire below_y   = idc_below(sample.y, ref_r.y, still_ref_r, still_limit_y);
	wire below_z   = idc_below(sample.z, ref_r.z, still_ref_r, still_limit_z);
	wire any_use   = still_use_x_r | still_use_y_r | still_use_z_r;
	// an axis left out always counts as still
	wire all_still = (below_x | ~still_use_x_r) & (below_y | ~still_use_y_r)
		& (below_z | ~still_use_z_r); // [R5] [R6]
	wire restart   = sample_valid & (~all_still | ~any_use); // [R13]
	wire mw_below  = idc_below(sample.x, mw_prev_r, mw_ref_r, motion_warn_limit_x);
	wire mw_hit    = sample_valid & mw_use_x_r & ~mw_below; // [R11]

	// code time base: 26 ms slow, 13 ms at the top rate
	wire [IDC_TICK_W-1:0] code_len = rate_6400 ? IDC_TICK_W'(CODE_FAST_CYC - 1)
		: IDC_TICK_W'(CODE_SLOW_CYC - 1); // [R8]
	logic [IDC_TICK_W-1:0] tick_r;
	logic [IDC_DUR_W-1:0]  count_r;
	wire code_tick  = tick_r >= code_len;
	// an interval with no enabled axis never ends in an event
	wire tracking   = any_use & ~restart;
	// with no axis in, count and time base stay cleared, so enabling an axis
	// later starts a fresh interval instead of reusing a stale count
	wire clear_cnt  = restart | ~any_use; // [R13]
	wire count_sat  = count_r == {IDC_DUR_W{1'b1}};
	wire [IDC_DUR_W-1:0] count_nxt = clear_cnt ? '0
		: (code_tick & tracking & ~count_sat) ? count_r + 1'b1 : count_r; // [R13]
	wire reached_nxt = tracking & (count_nxt >= still_duration); // [R6]

	// timer, references and outputs
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tick_r       <= '0;
			count_r      <= '0;
			ref_r        <= '0;
			mw_prev_r    <= '0;
			reg_rdata    <= 8'h00;
			still_event  <= 1'b0;
			still_active <= 1'b0;
			motion_warn  <= 1'b0;
		end
		else
		begin
			reg_rdata <= rd_mux;
			// restarting the time base too keeps every interval a whole number of codes
			tick_r    <= (clear_cnt | code_tick) ? '0 : tick_r + 1'b1;
			count_r   <= count_nxt; // [R13]
			if (restart)
				ref_r <= sample;
			if (sample_valid)
				mw_prev_r <= sample.x;
			still_active <= reached_nxt;
			still_event  <= reached_nxt & ~still_active; // [R6]
			motion_warn  <= mw_hit; // [R11]
		end
	end

endmodule : idc_top

// ### testbench/idc_top_props.sv
// assertion checker for the inactivity detect configuration ports
module idc_props
	import idc_pkg::*;
(
	input wire logic         sys_clk,
	input wire logic         rst,
	input wire idc_reg_req_t reg_req,
	input wire logic [7:0]   reg_rdata,
	input wire logic         sample_valid,
	input wire logic         still_event,
	input wire logic         still_active,
	input wire logic         motion_warn
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// address classes; keep_w is what survives a write into each register
	wire       map_w   = reg_req.addr inside {[IDC_ADDR_X_HIGH:IDC_ADDR_MW_LOW]};
	wire       lowx_w  = (reg_req.addr == IDC_ADDR_X_LOW) || (reg_req.addr == IDC_ADDR_MW_LOW);
	wire       lowyz_w = (reg_req.addr == IDC_ADDR_Y_LOW) || (reg_req.addr == IDC_ADDR_Z_LOW);
	wire [7:0] keep_w  = lowx_w ? 8'he3 : (lowyz_w ? 8'he1 : 8'hff);
	property p_wr_read;
		(reg_req.wr && map_w) ##1 (!reg_req.wr && $stable(reg_req.addr))
			|=> reg_rdata == ($past(reg_req.wdata, 2) & $past(keep_w, 2));
	endproperty
	a_wr_read: assert property (p_wr_read) else $error("written value not read back");
	property p_rsv_x;
		lowx_w |=> reg_rdata[4:2] == 3'h0;
	endproperty
	a_rsv_x: assert property (p_rsv_x) else $error("reserved x low bits not zero");
	property p_rsv_yz;
		lowyz_w |=> reg_rdata[4:1] == 4'h0;
	endproperty
	a_rsv_yz: assert property (p_rsv_yz) else $error("reserved y or z low bits not zero");
	property p_unmapped;
		!map_w |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped address read not zero");
	property p_ev_act;
		still_event |-> still_active;
	endproperty
	a_ev_act: assert property (p_ev_act) else $error("still event without still level");
	property p_ev_pulse;
		still_event |=> !still_event;
	endproperty
	a_ev_pulse: assert property (p_ev_pulse) else $error("still event longer than one cycle");
	property p_rise_ev;
		$rose(still_active) |-> still_event;
	endproperty
	a_rise_ev: assert property (p_rise_ev) else $error("still level rose without event");
	property p_fall_smp;
		$fell(still_active) |-> $past(sample_valid) || $past(reg_req.wr, 2);
	endproperty
	a_fall_smp: assert property (p_fall_smp) else $error("still level dropped without a sample or write");
	property p_warn_smp;
		motion_warn |-> $past(sample_valid);
	endproperty
	a_warn_smp: assert property (p_warn_smp) else $error("motion warning without a sample");
endmodule : idc_props

bind idc_top idc_props u_props (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.sample_valid(sample_valid), .still_event(still_event), .still_active(still_active), .motion_warn(motion_warn));

// ### testbench/tb_idc_top.sv
// self-checking bench for the inactivity detect configuration block
module tb_idc_top
	import idc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOW = 20;
	localparam int FAST = 10;
	logic         sys_clk, rst, sample_valid, rate_6400, still_event, still_active, motion_warn, w;
	idc_reg_req_t reg_req;
	idc_sample_t  sample;
	logic [7:0]   reg_rdata, a, v, d;
	int           seed = 91638;
	int           error_cnt = 0;
	int           checked = 0;
	int           n, c;

	idc_top #(.CODE_SLOW_CYC(SLOW), .CODE_FAST_CYC(FAST)) DUT (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample(sample), .rate_6400(rate_6400),
		.still_event(still_event), .still_active(still_active), .motion_warn(motion_warn));

	// free-running clock
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// expected read-back: reserved low bits and unmapped places read zero
	function automatic logic [7:0] keep(input logic [7:0] ad, input logic [7:0] val);
		if (ad == IDC_ADDR_X_LOW || ad == IDC_ADDR_MW_LOW)
			return val & 8'he3;
		if (ad == IDC_ADDR_Y_LOW || ad == IDC_ADDR_Z_LOW)
			return val & 8'he1;
		return (ad inside {[IDC_ADDR_X_HIGH:IDC_ADDR_MW_LOW]}) ? val : 8'h00;
	endfunction : keep

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// bus cycles start on a falling edge so the rising edge sees settled values
	task automatic wr(input logic [7:0] ad, input logic [7:0] val);
		@(negedge sys_clk);
		reg_req = '{1'b1, ad, val};
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [7:0] val);
		@(negedge sys_clk);
		reg_req = '{1'b0, ad, 8'h00};
		@(negedge sys_clk);
		val = reg_rdata;
	endtask : rd

	// y and z carry random noise; they must not matter while excluded
	task automatic smp(input logic signed [11:0] x, output logic wo);
		@(negedge sys_clk);
		sample = '{x, 12'($random(seed)), 12'($random(seed))};
		sample_valid = 1'b1;
		@(negedge sys_clk);
		sample_valid = 1'b0;
		wo = motion_warn;
	endtask : smp

	task automatic still_wait(output int cnt);
		cnt = 0;
		while (still_event !== 1'b1 && cnt < 200)
		begin
			@(negedge sys_clk);
			cnt++;
		end
	endtask : still_wait

	// y and z driven by hand, x held at zero
	task automatic smp_yz(input logic signed [11:0] y, input logic signed [11:0] z);
		@(negedge sys_clk);
		sample = '{12'sd0, y, z};
		sample_valid = 1'b1;
		@(negedge sys_clk);
		sample_valid = 1'b0;
	endtask : smp_yz

	// every place in and around the map reads zero after a reset
	task automatic reg_zero_check();
		logic [7:0] rv;
		for (int i = 8'h29; i <= 8'h34; i++)
		begin
			rd(8'(i), rv);
			chk("reset_value", 8'h00, rv);
		end
	endtask : reg_zero_check

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// hang guard, far beyond the several hundred cycles the tests need
	initial
	begin
		#200000;
		error_cnt++;
		complete_run();
	end

	initial
	begin
		rst = 1'b1;
		reg_req = '0;
		sample_valid = 1'b0;
		sample = '0;
		rate_6400 = 1'b0;
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		reg_zero_check();
		repeat (30)
		begin
			a = 8'h28 + 8'($unsigned($random(seed)) % 14);
			v = 8'($random(seed));
			wr(a, v);
			rd(a, d);
			chk("readback", keep(a, v), d);
		end
		// x limit 5 absolute and enabled, y and z out, duration two codes, warning limit 8
		wr(IDC_ADDR_X_HIGH, 8'h00);
		wr(IDC_ADDR_X_LOW, 8'ha1);
		wr(IDC_ADDR_Y_LOW, 8'h00);
		wr(IDC_ADDR_Z_LOW, 8'h00);
		wr(IDC_ADDR_TIME_HI, 8'h00);
		wr(IDC_ADDR_TIME_LO, 8'h02);
		wr(IDC_ADDR_MW_HIGH, 8'h01);
		wr(IDC_ADDR_MW_LOW, 8'h01);
		for (int r = 0; r < 2; r++)
		begin
			rate_6400 = r[0];
			c = r ? FAST : SLOW;
			smp(-12'sd7, w);
			chk("warn_below", 8'h00, {7'h0, w});
			still_wait(n);
			chk("still_time", 8'h01, {7'h0, n >= 2 * c && n <= 2 * c + 3});
			smp(-12'sd4, w);
			@(negedge sys_clk);
			chk("still_kept", 8'h01, {7'h0, still_active});
			smp(12'sd5, w);
			@(negedge sys_clk);
			chk("still_restart", 8'h00, {7'h0, still_active});
		end
		rate_6400 = 1'b0;
		smp(-12'sd8, w);
		chk("warn_at_limit", 8'h01, {7'h0, w});
		wr(IDC_ADDR_MW_LOW, 8'h03);
		smp(-12'sd8, w);
		chk("warn_ref_same", 8'h00, {7'h0, w});
		smp(12'sd0, w);
		chk("warn_ref_step", 8'h01, {7'h0, w});
		// referenced stillness: a large but steady value must not restart the count
		wr(IDC_ADDR_X_LOW, 8'ha3);
		smp(12'sd100, w);
		repeat (SLOW) @(negedge sys_clk);
		smp(12'sd103, w);
		still_wait(n);
		chk("ref_still", 8'h01, {7'h0, n >= SLOW - 3 && n <= SLOW + 3});
		// x out, y and z in with limit 5; dropping x alone empties the set for a moment
		wr(IDC_ADDR_X_LOW, 8'ha0);
		wr(IDC_ADDR_Y_HIGH, 8'h00);
		wr(IDC_ADDR_Y_LOW, 8'ha1);
		wr(IDC_ADDR_Z_HIGH, 8'h00);
		wr(IDC_ADDR_Z_LOW, 8'ha1);
		smp_yz(12'sd6, 12'sd0);
		smp_yz(-12'sd3, 12'sd4);
		still_wait(n);
		chk("still_yz", 8'h01, {7'h0, n >= 2 * SLOW - 3 && n <= 2 * SLOW + 3});
		smp_yz(12'sd0, -12'sd5);
		@(negedge sys_clk);
		chk("still_restart_z", 8'h00, {7'h0, still_active});
		// no axis in: never still, even with a zero duration
		wr(IDC_ADDR_Y_LOW, 8'h00);
		wr(IDC_ADDR_Z_LOW, 8'h00);
		wr(IDC_ADDR_TIME_LO, 8'h00);
		smp_yz(12'sd0, 12'sd0);
		still_wait(n);
		chk("no_axis", 8'h00, {7'h0, n < 200 || still_active});
		// zero duration: still at once when an axis comes in
		wr(IDC_ADDR_Y_LOW, 8'ha1);
		@(negedge sys_clk);
		chk("dur_zero", 8'h01, {7'h0, still_active});
		// reset in mid-run with the still level up: outputs and registers clear
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("reset_still", 8'h00, {7'h0, still_active});
		rst = 1'b0;
		reg_zero_check();
		complete_run();
	end
endmodule : tb_idc_top
